// ===== pkg/dsm_pkg.sv
/*
  Shared constants and carrier types for the digital side of a second-order
  delta-sigma modulator model. Assumes a single system clock of 20 MHz.
*/
package dsm_pkg;

  // ****************************************************
  // widths and AXI4-Lite register map
  // ****************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int ACC_W = 24;
  localparam logic [ADDR_W-1:0] CTRL_OFFS = 8'h00;
  localparam logic [ADDR_W-1:0] INPUT_OFFS = 8'h04;
  localparam logic [ADDR_W-1:0] CLKDIV_OFFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 8'h0C;
  localparam logic [ADDR_W-1:0] ONES_OFFS = 8'h10;
  localparam logic [ADDR_W-1:0] CYCLES_OFFS = 8'h14;

  // ctrl field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_GAIN_SEL_BIT = 1;
  localparam int CTRL_CAL_N_BIT = 2;
  localparam int CTRL_REF_EN_BIT = 3;
  localparam int CTRL_BIAS_EN_BIT = 4;
  localparam int CTRL_PIN_SRC_BIT = 5;

  // reset values
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0004;
  localparam logic [DATA_W-1:0] INPUT_RESET = 32'h0000_0000;
  // modulator clock 320 kHz from 20 MHz: divide by 62
  localparam logic [15:0] CLKDIV_RESET = 16'h003E;
  // 20 kHz .. 1 MHz at 20 MHz: divider 20..1000
  localparam logic [15:0] CLKDIV_MIN = 16'h0014;
  localparam logic [15:0] CLKDIV_MAX = 16'h03E8;

  // ****************************************************
  // analog scaling, input code is signed, full scale = +/-FS_CODE (5 V)
  // density = 0.5 + 0.4*x/FS, so feedback levels are +/- FS/0.8
  // ****************************************************
  localparam int FS_CODE = 20000;
  localparam int FB_LEVEL = 25000;
  localparam int REF_CODE = 10000;
  localparam logic [1:0] SRC_NORMAL = 2'h0;
  localparam logic [1:0] SRC_OFFSET = 2'h1;
  localparam logic [1:0] SRC_FULL = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_OFFSET = 2'b01,
    MODE_FULL = 2'b11
  } cal_mode_t;

  typedef struct packed {
    logic gain_sel;
    logic cal_n;
    logic ref_en;
    logic bias_en;
  } pin_ctrl_t;

  typedef struct packed {
    logic ref_drive;
    logic bias_drive;
  } analog_en_t;

endpackage

// ===== src/dsm_sync.sv
/*
  Three-flop synchroniser with agreement filter for asynchronous pins.
  Assumes aclk domain and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dsm_sync #(
  parameter int W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  always_comb begin
    out_d = out_q;
    // first stage feeds only the second
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule
`default_nettype wire

// ===== src/dsm_modulator.sv
/*
  Second-order delta-sigma loop: two integrators and a one-bit quantiser,
  advanced once per modulator-clock enable. Assumes aclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dsm_modulator (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step_en,
  input wire logic signed [dsm_pkg::ACC_W-1:0] sample,
  output logic bit_out
);
  logic signed [dsm_pkg::ACC_W+3:0] int1_q, int1_d, int2_q, int2_d, fb;
  logic bit_q, bit_d;

  always_comb begin
    fb = bit_q ? (dsm_pkg::ACC_W+4)'(dsm_pkg::FB_LEVEL) : -(dsm_pkg::ACC_W+4)'(dsm_pkg::FB_LEVEL);
    int1_d = int1_q;
    int2_d = int2_q;
    bit_d = bit_q;
    if (step_en) begin
      // dac answers the previous decision, one step later
      int1_d = int1_q + (dsm_pkg::ACC_W+4)'(sample) - fb;
      int2_d = int2_q + int1_d - fb;
      bit_d = !int2_d[dsm_pkg::ACC_W+3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int1_q <= '0;
      int2_q <= '0;
      bit_q <= 1'b0;
    end else begin
      int1_q <= int1_d;
      int2_q <= int2_d;
      bit_q <= bit_d;
    end
  end

  assign bit_out = bit_q;
endmodule
`default_nettype wire

// ===== src/dsm_top.sv
/*
  Digital side of a delta-sigma modulator with calibration switching,
  reference and bias enables, and an AXI4-Lite register slave.
  Assumes one 20 MHz clock, synchronous active-low reset, and a receiver
  that samples the stream on the falling modulator-clock edge.
*/
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
// Function
// - modulator clock enable paces sampling, loop and output framing together.
// - zero input gives half ones density.
// - plus five volts gives ninety percent ones.
// - minus five volts gives ten percent ones.
// - active-low cal enable; gain-select 0 with cal low grounds inputs.
// - gain-select 1 with cal low references inputs to reference voltage; the code feeds the full-scale FS_CODE (5 V) instead.
// - calibration modes still output a normal stream.
// - reference output drives 2.5 V only when enabled, else high impedance.
// - bias output drives 1.33 times reference only when enabled.
`timescale 1ns/1ps
`default_nettype none
module dsm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dsm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dsm_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dsm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dsm_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic gain_sel_pin,
  input wire logic cal_n_pin,
  input wire logic ref_en_pin,
  input wire logic bias_en_pin,
  output logic mod_clk,
  output logic density_bitstream_out,
  output logic ref_out_oe_n,
  output logic bias_out_oe_n
);

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic dsm_pkg::cal_mode_t decode_mode(input dsm_pkg::pin_ctrl_t p);
    if (p.cal_n) begin
      return dsm_pkg::MODE_NORMAL;
    end else if (p.gain_sel) begin
      return dsm_pkg::MODE_FULL;
    end else begin
      return dsm_pkg::MODE_OFFSET;
    end
  endfunction

  // ****************************************************
  // registers
  // ****************************************************
  logic [31:0] ctrl_q, ctrl_d, input_q, input_d;
  logic [15:0] div_q, div_d;
  logic [31:0] ones_q, ones_d, cyc_q, cyc_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d;
  logic [dsm_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_write, do_read;

  // ****************************************************
  // pin synchronisers and mode
  // ****************************************************
  logic [3:0] pins_sync;
  dsm_sync #(.W(4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({gain_sel_pin, cal_n_pin, ref_en_pin, bias_en_pin}),
    .sync_out(pins_sync)
  );

  dsm_pkg::pin_ctrl_t pins;
  dsm_pkg::cal_mode_t mode;
  dsm_pkg::analog_en_t aen;
  always_comb begin
    if (ctrl_q[dsm_pkg::CTRL_PIN_SRC_BIT]) begin
      pins = dsm_pkg::pin_ctrl_t'(pins_sync);
    end else begin
      pins.gain_sel = ctrl_q[dsm_pkg::CTRL_GAIN_SEL_BIT];
      pins.cal_n = ctrl_q[dsm_pkg::CTRL_CAL_N_BIT];
      pins.ref_en = ctrl_q[dsm_pkg::CTRL_REF_EN_BIT];
      pins.bias_en = ctrl_q[dsm_pkg::CTRL_BIAS_EN_BIT];
    end
    mode = decode_mode(pins);
    aen.ref_drive = pins.ref_en;
    aen.bias_drive = pins.bias_en;
  end

  // ****************************************************
  // modulator clock divider
  // ****************************************************
  logic [15:0] cnt_q, cnt_d;
  logic mclk_q, mclk_d, rise_en;
  logic [15:0] div_eff;
  always_comb begin
    // out-of-range divider values are clamped to the supported clock range
    if (div_q < dsm_pkg::CLKDIV_MIN) begin
      div_eff = dsm_pkg::CLKDIV_MIN;
    end else if (div_q > dsm_pkg::CLKDIV_MAX) begin
      div_eff = dsm_pkg::CLKDIV_MAX;
    end else begin
      div_eff = div_q;
    end
    cnt_d = cnt_q;
    mclk_d = mclk_q;
    rise_en = 1'b0;
    if (ctrl_q[dsm_pkg::CTRL_RUN_BIT]) begin
      if (cnt_q >= div_eff - 16'h0001) begin
        cnt_d = '0;
        mclk_d = 1'b1;
        rise_en = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
        // fixed half-period split keeps the duty cycle constant
        if (cnt_q == (div_eff >> 1) - 16'h0001) begin
          mclk_d = 1'b0;
        end
      end
    end else begin
      cnt_d = '0;
      mclk_d = 1'b0;
    end
  end

  // ****************************************************
  // input selection and loop
  // ****************************************************
  logic signed [dsm_pkg::ACC_W-1:0] sample;
  always_comb begin
    case (mode)
      dsm_pkg::MODE_OFFSET: sample = '0;
      dsm_pkg::MODE_FULL: sample = dsm_pkg::ACC_W'(dsm_pkg::FS_CODE);
      default: sample = input_q[dsm_pkg::ACC_W-1:0];
    endcase
  end

  logic bit_w;
  dsm_modulator u_mod (
    .aclk(aclk),
    .aresetn(aresetn),
    .step_en(rise_en),
    .sample(sample),
    .bit_out(bit_w)
  );

  // ****************************************************
  // density counters for software observation
  // ****************************************************
  always_comb begin
    ones_d = ones_q;
    cyc_d = cyc_q;
    if (do_write && awaddr_q == dsm_pkg::ONES_OFFS) begin
      ones_d = '0;
      cyc_d = '0;
    end else if (rise_en) begin
      ones_d = ones_q + {31'h0, bit_w};
      cyc_d = cyc_q + 32'h1;
    end
  end

  // ****************************************************
  // AXI4-Lite slave
  // ****************************************************
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    input_d = input_q;
    div_d = div_q;
    do_write = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_held_q && w_held_q && !bvalid_q) begin
      do_write = 1'b1;
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = 2'h0;
      if (awaddr_q == dsm_pkg::CTRL_OFFS) begin
        ctrl_d = merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_003F;
      end else if (awaddr_q == dsm_pkg::INPUT_OFFS) begin
        input_d = merge(input_q, wdata_q, wstrb_q);
      end else if (awaddr_q == dsm_pkg::CLKDIV_OFFS) begin
        div_d = 16'(merge({16'h0, div_q}, wdata_q, wstrb_q));
      end else if (awaddr_q == dsm_pkg::ONES_OFFS) begin
        bresp_d = 2'h0;
      end else begin
        bresp_d = 2'h2;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign do_read = s_axi_arvalid && !rvalid_q;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (do_read) begin
      rvalid_d = 1'b1;
      rresp_d = 2'h0;
      if (s_axi_araddr == dsm_pkg::CTRL_OFFS) begin
        rdata_d = ctrl_q;
      end else if (s_axi_araddr == dsm_pkg::INPUT_OFFS) begin
        rdata_d = input_q;
      end else if (s_axi_araddr == dsm_pkg::CLKDIV_OFFS) begin
        rdata_d = {16'h0, div_q};
      end else if (s_axi_araddr == dsm_pkg::STATUS_OFFS) begin
        rdata_d = {26'h0, aen.bias_drive, aen.ref_drive, mode, mclk_q, bit_w};
      end else if (s_axi_araddr == dsm_pkg::ONES_OFFS) begin
        rdata_d = ones_q;
      end else if (s_axi_araddr == dsm_pkg::CYCLES_OFFS) begin
        rdata_d = cyc_q;
      end else begin
        rdata_d = 32'h0;
        rresp_d = 2'h2;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= dsm_pkg::CTRL_RESET;
      input_q <= dsm_pkg::INPUT_RESET;
      div_q <= dsm_pkg::CLKDIV_RESET;
      ones_q <= '0;
      cyc_q <= '0;
      cnt_q <= '0;
      mclk_q <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      input_q <= input_d;
      div_q <= div_d;
      ones_q <= ones_d;
      cyc_q <= cyc_d;
      cnt_q <= cnt_d;
      mclk_q <= mclk_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // bit changes with the rising edge, stable for the falling-edge sampler
  assign mod_clk = mclk_q;
  assign density_bitstream_out = bit_w;
  // low enable means driving; high means high impedance
  assign ref_out_oe_n = !aen.ref_drive;
  assign bias_out_oe_n = !aen.bias_drive;

endmodule
`default_nettype wire

// ===== verification/dsm_top_asserts.sv
/*
  Checker for dsm_top: bus handshakes and stream framing.
  Assumes it is bound onto the dsm_top ports, aclk domain only.
*/
`timescale 1ns/1ps
`default_nettype none
module dsm_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [dsm_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mod_clk,
  input wire logic density_bitstream_out
);
  // ****************************************************
  // properties
  // ****************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_stream_framed: assert property (!$rose(mod_clk) |-> $stable(density_bitstream_out))
    else $error("stream bit moved without a modulator clock rise");
  // divider floor is 20 cycles, so no two rises closer than 9
  a_clk_spacing: assert property ($rose(mod_clk) |=> !$rose(mod_clk) [*8])
    else $error("modulator clock rises too close together");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after handshake");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_resp_code: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
    else $error("unexpected read response code");
  c_stream_one: cover property ($rose(mod_clk) && density_bitstream_out);
  c_write_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind dsm_top dsm_top_asserts u_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mod_clk(mod_clk),
  .density_bitstream_out(density_bitstream_out)
);
`default_nettype wire

// ===== verification/stream_receiver_model.sv
/*
  Receiver of the density stream: counts ones over a fixed window.
  Assumes the modulator clock comes from the device under test.
*/
`timescale 1ns/1ps
`default_nettype none
module stream_receiver_model #(
  parameter int WIN = 400
) (
  input wire logic mod_clk,
  input wire logic stream_in,
  input wire logic clear,
  output var int ones,
  output var int samples
);
  // ****************************************************
  // sinc counter
  // ****************************************************
  // falling edge keeps clear of the bit change at the rise
  always @(negedge mod_clk or posedge clear) begin
    if (clear) begin
      ones <= 0;
      samples <= 0;
    end else if (samples < WIN) begin
      samples <= samples + 1;
      ones <= ones + int'(stream_in === 1'h1);
    end
  end
endmodule
`default_nettype wire

// ===== verification/test_delta_sigma_bitstream_calibration.sv
/*
  Bench for dsm_top: registers, enables, calibration modes, density.
  Assumes dsm_pkg, the checker and the stream receiver model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_delta_sigma_bitstream_calibration;
  localparam int WIN = 400;
  localparam int desired_full_scale_code = 1000;
  localparam dsm_pkg::pin_ctrl_t PIN_TAB [3] = '{4'h6, 4'h1, 4'hB};
  localparam dsm_pkg::cal_mode_t MODE_TAB [3] = '{dsm_pkg::MODE_NORMAL, dsm_pkg::MODE_OFFSET, dsm_pkg::MODE_FULL};
  localparam logic [31:0] CTRL_TAB [5] = '{32'h1, 32'h3, 32'h5, 32'h5, 32'h5};
  localparam logic [31:0] IN_TAB [5] = '{32'h4E20, 32'hFFFF_B1E0, 32'h0, 32'h4E20, 32'hFFFF_B1E0};
  localparam int TENTHS [5] = '{5, 9, 5, 9, 1};
  logic aclk = 1'h0, aresetn = 1'h0, clear = 1'h0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic gain_sel_pin = 1'h0, cal_n_pin = 1'h1, ref_en_pin = 1'h0, bias_en_pin = 1'h0;
  logic mod_clk, density_bitstream_out, ref_out_oe_n, bias_out_oe_n;
  int ones, samples, n_mismatch = 0, checks_done = 0, cycles_run = 0, hi_len = 0;
  logic duty_on = 1'h0;

  dsm_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .gain_sel_pin(gain_sel_pin),
    .cal_n_pin(cal_n_pin), .ref_en_pin(ref_en_pin), .bias_en_pin(bias_en_pin), .mod_clk(mod_clk),
    .density_bitstream_out(density_bitstream_out), .ref_out_oe_n(ref_out_oe_n), .bias_out_oe_n(bias_out_oe_n));
  stream_receiver_model #(.WIN(WIN)) i_rx (.mod_clk(mod_clk), .stream_in(density_bitstream_out),
    .clear(clear), .ones(ones), .samples(samples));

  initial begin
    forever #25 aclk = ~aclk;
  end

  // ****************************************************
  // bus tasks and checks
  // ****************************************************
  // stall holds the answer ready low for a few cycles to test holding
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int stall, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'h1) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready === 1'h1) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    repeat (stall) @(posedge aclk);
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input int stall, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    repeat (stall) @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // at a divider of 20 every high phase of the modulator clock lasts ten system clocks
  always @(posedge aclk) begin
    hi_len <= (mod_clk === 1'h1) ? hi_len + 1 : 0;
    if (duty_on && mod_clk !== 1'h1 && hi_len != 0) begin
      check(hi_len, 32'hA);
    end
  end

  // density runs dominate: five windows of 400 bits at 20 cycles each
  always @(posedge aclk) begin
    cycles_run <= cycles_run + 1;
    if (cycles_run == 80000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ****************************************************
  // scenarios
  // ****************************************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n [5];
    int q, offset_filter_result, gain_filter_result, measured_filter_result;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check(ref_out_oe_n, 1'h1);
    check(bias_out_oe_n, 1'h1);
    rd(dsm_pkg::CTRL_OFFS, 0, d, r);
    check(d, dsm_pkg::CTRL_RESET);
    rd(dsm_pkg::CLKDIV_OFFS, 2, d, r);
    check(d, 32'h3E);
    rd(8'h18, 1, d, r);
    check(d, 32'h0);
    check(r, 2'h2);
    wr(8'h1C, 32'h1, 2, r);
    check(r, 2'h2);
    for (int k = 0; k < 4; k++) begin
      wr(dsm_pkg::CTRL_OFFS, 32'h4 | 32'(k << 3), 0, r);
      repeat (2) @(posedge aclk);
      check(ref_out_oe_n, !k[0]);
      check(bias_out_oe_n, !k[1]);
    end
    wr(dsm_pkg::CTRL_OFFS, 32'h20, 1, r);
    for (int i = 0; i < 3; i++) begin
      {gain_sel_pin, cal_n_pin, ref_en_pin, bias_en_pin} <= PIN_TAB[i];
      repeat (6) @(posedge aclk);
      rd(dsm_pkg::STATUS_OFFS, 0, d, r);
      check(d[3:2], MODE_TAB[i]);
      check({d[4], d[5], ref_out_oe_n, bias_out_oe_n}, {PIN_TAB[i][1:0], ~PIN_TAB[i][1:0]});
    end
    wr(dsm_pkg::CLKDIV_OFFS, 32'h14, 0, r);
    duty_on <= 1'h1;
    // offset, then gain, then normal inputs, after the register, enable and pin checks
    for (int i = 0; i < 5; i++) begin
      wr(dsm_pkg::INPUT_OFFS, IN_TAB[i], 0, r);
      wr(dsm_pkg::CTRL_OFFS, CTRL_TAB[i], 0, r);
      repeat (1000) @(posedge aclk);
      clear <= 1'h1;
      @(posedge aclk);
      clear <= 1'h0;
      while (samples != WIN) @(posedge aclk);
      n[i] = ones;
      q = ones * 10 - WIN * TENTHS[i];
      check(q < 61 && q > -61, 1'h1);
    end
    offset_filter_result = n[0];
    gain_filter_result = n[1];
    measured_filter_result = n[3];
    q = desired_full_scale_code * (measured_filter_result - offset_filter_result)
      / (gain_filter_result - offset_filter_result);
    check(q > 950 && q < 1050, 1'h1);
    q = dsm_pkg::REF_CODE * (n[4] - offset_filter_result) / (gain_filter_result - offset_filter_result);
    check(q > -10500 && q < -9500, 1'h1);
    // system calibration: the zero and full-scale normal-mode windows act as the two known levels
    q = dsm_pkg::FS_CODE * (n[4] - n[2]) / (n[3] - n[2]);
    check(q > -21000 && q < -19000, 1'h1);
    rd(dsm_pkg::CYCLES_OFFS, 0, d, r);
    check(d > 32'h7D0, 1'h1);
    // a stop cuts the running high phase, so the duty check is switched off first
    duty_on <= 1'h0;
    wr(dsm_pkg::CTRL_OFFS, 32'h4, 0, r);
    wr(dsm_pkg::ONES_OFFS, 32'h0, 0, r);
    check(r, 2'h0);
    rd(dsm_pkg::ONES_OFFS, 0, d, r);
    check(d, 32'h0);
    rd(dsm_pkg::CYCLES_OFFS, 0, d, r);
    check(d, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
